// ==== logic/cfp_pkg.sv ====
// Constants, carriers and decode for the configuration fuse block.
// Assumes one 125 MHz clock and a synchronous active-high reset.
package cfp_pkg;

    // =====================================================
    // Address map
    localparam logic [21:0] ADDR_BOR     = 22'h30_0002;
    localparam logic [21:0] ADDR_WDT     = 22'h30_0003;
    localparam logic [21:0] ADDR_DBG     = 22'h30_0006;
    localparam logic [21:0] ADDR_PROT    = 22'h30_0009;
    localparam logic [21:0] ADDR_ID_BASE = 22'h20_0000;
    localparam logic [21:0] ADDR_EE_BASE = 22'h3F_0000;
    localparam int          ID_COUNT     = 8;

    // =====================================================
    // Field positions, masks and erased values
    localparam int          BOR_LVL_LSB  = 2;
    localparam int          BOR_ON_BIT   = 1;
    localparam int          POWERUP_TIMER_OFF_BIT = 0;
    localparam int          WDT_PS_LSB   = 1;
    localparam int          WDT_ON_BIT   = 0;
    localparam int          DBG_OFF_BIT  = 7;
    localparam int          LVP_BIT      = 2;
    localparam int          PROT_EEA_BIT = 0;
    localparam int          PROT_EEW_BIT = 1;
    localparam int          PROT_CWL_BIT = 2;
    localparam logic [7:0]  CFG_MASK     = 8'h0F;
    localparam logic [7:0]  DBG_MASK     = 8'h84;
    localparam logic [7:0]  PROT_MASK    = 8'h07;
    localparam logic [7:0]  CFG_ERASED   = 8'h0F;
    localparam logic [7:0]  DBG_ERASED   = 8'h84;
    localparam logic [7:0]  PROT_ERASED  = 8'h07;
    localparam logic [7:0]  ID_ERASED    = 8'hFF;

    // =====================================================
    // Brown-out thresholds in millivolts
    localparam logic [12:0] BOR_MV_CODE3 = 13'h09C4;
    localparam logic [12:0] BOR_MV_CODE2 = 13'h0A8C;
    localparam logic [12:0] BOR_MV_CODE1 = 13'h1068;
    localparam logic [12:0] BOR_MV_CODE0 = 13'h1194;

    // =====================================================
    // Debugger reservations
    localparam logic [1:0]  DBG_STACK_LEVELS = 2'h2;
    localparam logic [9:0]  DBG_PROG_BYTES   = 10'h240;
    localparam logic [3:0]  DBG_DATA_BYTES   = 4'hA;

    // =====================================================
    // Serial link frame: write flag, 22 address bits, 8 data bits
    localparam logic [4:0]  LINK_HDR_LAST   = 5'h16;
    localparam logic [4:0]  LINK_FRAME_LAST = 5'h1E;

    typedef enum logic [2:0] {
        MODE_USER = 3'b001,
        MODE_LV   = 3'b010,
        MODE_HV   = 3'b100
    } cfp_mode_t;

    typedef struct packed {
        logic [12:0] bor_mv;
        logic        bor_on;
        logic        powerup_timer_on;
        logic [7:0]  wdt_ratio;
        logic        wdt_fuse;
        logic        debug_on;
        logic        lvp_on;
    } cfp_cfg_t;

    typedef struct packed {
        logic [21:0] addr;
        logic        is_write;
        logic [7:0]  data;
    } cfp_frame_t;

    function automatic cfp_cfg_t cfp_decode(input logic [7:0] bor,
                                            input logic [7:0] wdt,
                                            input logic [7:0] dbg);
        cfp_cfg_t r;
        unique case (bor[BOR_LVL_LSB +: 2])
            2'h3: r.bor_mv = BOR_MV_CODE3;
            2'h2: r.bor_mv = BOR_MV_CODE2;
            2'h1: r.bor_mv = BOR_MV_CODE1;
            2'h0: r.bor_mv = BOR_MV_CODE0;
        endcase
        r.bor_on    = bor[BOR_ON_BIT];
        r.powerup_timer_on   = ~bor[POWERUP_TIMER_OFF_BIT];
        r.wdt_ratio = 8'h01 << wdt[WDT_PS_LSB +: 3];
        r.wdt_fuse  = wdt[WDT_ON_BIT];
        r.debug_on  = ~dbg[DBG_OFF_BIT];
        r.lvp_on    = dbg[LVP_BIT];
        return r;
    endfunction : cfp_decode

endpackage : cfp_pkg

// ==== logic/cfp_sync.sv ====
// Two-stage synchroniser for the four programming pins.
// Assumes inputs are asynchronous to clk.
module cfp_sync
    import cfp_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Pins in, synchronised out
    input  wire logic [3:0] d,
    output logic      [3:0] q
);
    logic [3:0] meta;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta <= 4'h0;
            q    <= 4'h0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule : cfp_sync

// ==== logic/cfp_link.sv ====
// Serial programming link: shifts frames in, a reply byte out.
// Assumes synchronised pin levels; link clock far slower than clk.
module cfp_link
    import cfp_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Synchronised link pins
    input  wire logic       active,
    input  wire logic       sclk_s,
    input  wire logic       sdat_s,
    // Reply byte
    input  wire logic       tx_load,
    input  wire logic [7:0] tx_byte,
    // Decoded frame
    output logic            hdr_done,
    output logic            frame_done,
    output cfp_frame_t      frame,
    output logic            sdo,
    output logic            sdo_oe
);
    logic        sclk_d;
    logic [4:0]  bit_cnt;
    logic [22:0] hdr;
    logic [7:0]  dat;
    logic [7:0]  tx;
    logic        rise;
    logic        fall;

    assign rise  = sclk_s & ~sclk_d;
    assign fall  = ~sclk_s & sclk_d;
    assign frame = {hdr[22:1], hdr[0], dat};

    always_ff @(posedge clk) begin
        if (rst) begin
            sclk_d <= 1'b0;
        end else begin
            sclk_d <= sclk_s;
        end
    end

    // =====================================================
    // Bit counting and shifting, LSB first
    always_ff @(posedge clk) begin
        if (rst || !active) begin
            bit_cnt    <= 5'h00;
            hdr_done   <= 1'b0;
            frame_done <= 1'b0;
        end else begin
            hdr_done   <= rise && (bit_cnt == LINK_HDR_LAST);
            frame_done <= rise && (bit_cnt == LINK_FRAME_LAST);
            if (rise) begin
                bit_cnt <= (bit_cnt == LINK_FRAME_LAST) ? 5'h00 : bit_cnt + 5'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            hdr <= 23'h000000;
            dat <= 8'h00;
        end else if (rise && active) begin
            if (bit_cnt <= LINK_HDR_LAST) begin
                hdr <= {sdat_s, hdr[22:1]};
            end else begin
                dat <= {sdat_s, dat[7:1]};
            end
        end
    end

    // =====================================================
    // Reply: bits change on falling link edges
    always_ff @(posedge clk) begin
        if (rst || !active) begin
            tx     <= 8'h00;
            sdo    <= 1'b0;
            sdo_oe <= 1'b0;
        end else if (tx_load) begin
            tx     <= tx_byte;
            sdo_oe <= 1'b1;
        end else if (frame_done) begin
            sdo_oe <= 1'b0;
        end else if (fall && sdo_oe) begin
            sdo <= tx[0];
            tx  <= {1'b0, tx[7:1]};
        end
    end
endmodule : cfp_link

// ==== logic/cfp_top.sv ====
// Configuration fuse block: fuse bytes, protection, ID bytes,
// debugger reservations and programming-mode entry.
// Assumes CPU table ports on clk; programming pins asynchronous.
module cfp_top
    import cfp_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // CPU table access
    input  wire logic        tbl_rd,
    input  wire logic        tbl_wr,
    input  wire logic [21:0] tbl_addr,
    input  wire logic [7:0]  tbl_wdata,
    output logic      [7:0]  tbl_rdata,
    output logic             tbl_ack,
    // Watchdog software control
    input  wire logic        watchdog_soft_on,
    output logic             watchdog_run,
    // Programming pins
    input  wire logic        prog_clk_pin,
    input  wire logic        prog_data_in,
    output logic             prog_data_out,
    output logic             prog_data_oe,
    input  wire logic        prog_entry_pin,
    input  wire logic        high_prog_voltage,
    output logic             prog_mode,
    output logic             prog_hv_mode,
    output logic             pin5_gpio,
    // Data eeprom, external path
    output logic             ee_ext_rd,
    output logic             ee_ext_wr,
    output logic      [9:0]  ee_ext_addr,
    output logic      [7:0]  ee_ext_wdata,
    input  wire logic [7:0]  ee_rdata,
    output logic             cpu_ee_allow,
    // Decoded configuration
    output cfp_cfg_t         cfg_out,
    // Debugger reservations
    output logic             dbg_pins_reserved,
    output logic      [1:0]  dbg_stack_levels,
    output logic      [9:0]  dbg_prog_bytes,
    output logic      [3:0]  dbg_data_bytes
);
    cfp_mode_t   mode;
    logic [3:0]  pins_s;
    logic        sclk_s;
    logic        sdat_s;
    logic        pgm_s;
    logic        hv_s;
    logic [7:0]  cfg_bor;
    logic [7:0]  cfg_wdt;
    logic [7:0]  cfg_dbg;
    logic [7:0]  cfg_prot;
    logic [7:0]  id_mem [ID_COUNT];
    logic        hdr_done;
    logic        frame_done;
    cfp_frame_t  frame;
    logic        rd_pend;
    logic [7:0]  tx_byte;
    logic        prog_act;
    logic        pw;
    logic        cw;
    logic        cfg_locked;
    logic        ee_rd_ok;
    logic        ee_wr_ok;

    function automatic logic is_id(input logic [21:0] a);
        return a[21:3] == ADDR_ID_BASE[21:3];
    endfunction : is_id

    function automatic logic is_ee(input logic [21:0] a);
        return a[21:10] == ADDR_EE_BASE[21:10];
    endfunction : is_ee

    function automatic logic [7:0] read_byte(input logic [21:0] a);
        logic [7:0] r;
        r = 8'h00;
        if (is_id(a)) begin
            r = id_mem[a[2:0]];
        end else begin
            case (a)
                ADDR_BOR:  r = cfg_bor & CFG_MASK;
                ADDR_WDT:  r = cfg_wdt & CFG_MASK;
                ADDR_DBG:  r = cfg_dbg & DBG_MASK;
                ADDR_PROT: r = cfg_prot & PROT_MASK;
                default:   r = 8'h00;
            endcase
        end
        return r;
    endfunction : read_byte

    // Allow bit only moves when entry was by high voltage
    function automatic logic [7:0] merge_dbg(input logic [7:0] old_v,
                                             input logic [7:0] new_v,
                                             input logic       lvp_ok);
        logic [7:0] r;
        r = new_v & DBG_MASK;
        if (!lvp_ok) begin
            r[LVP_BIT] = old_v[LVP_BIT];
        end
        return r;
    endfunction : merge_dbg

    // =====================================================
    // Pin synchronisers and serial link
    cfp_sync cfp_sync_inst (
        .clk (clk),
        .rst (rst),
        .d   ({prog_clk_pin, prog_data_in, prog_entry_pin, high_prog_voltage}),
        .q   (pins_s)
    );

    assign sclk_s = pins_s[3];
    assign sdat_s = pins_s[2];
    assign pgm_s  = pins_s[1];
    assign hv_s   = pins_s[0];

    assign prog_act   = (mode != MODE_USER);
    assign pw         = frame_done && frame.is_write && prog_act;
    assign cw         = tbl_wr && (mode == MODE_USER);
    assign cfg_locked = ~cfg_prot[PROT_CWL_BIT];
    assign ee_rd_ok   = cfg_prot[PROT_EEA_BIT];
    assign ee_wr_ok   = cfg_prot[PROT_EEA_BIT] & cfg_prot[PROT_EEW_BIT];
    // Locked eeprom reads answer zero rather than stalling the link;
    // a process so that stored bytes read by the function are seen
    always_comb begin
        tx_byte = is_ee(frame.addr) ? (ee_rd_ok ? ee_rdata : 8'h00)
                                    : read_byte(frame.addr);
    end

    cfp_link cfp_link_inst (
        .clk        (clk),
        .rst        (rst),
        .active     (prog_act),
        .sclk_s     (sclk_s),
        .sdat_s     (sdat_s),
        .tx_load    (rd_pend),
        .tx_byte    (tx_byte),
        .hdr_done   (hdr_done),
        .frame_done (frame_done),
        .frame      (frame),
        .sdo        (prog_data_out),
        .sdo_oe     (prog_data_oe)
    );

    // =====================================================
    // Programming-mode entry
    always_ff @(posedge clk) begin
        if (rst) begin
            mode <= MODE_USER;
        end else begin
            unique case (mode)
                MODE_USER: begin
                    if (hv_s) begin
                        mode <= MODE_HV;
                    end else if (pgm_s && cfg_dbg[LVP_BIT]) begin
                        mode <= MODE_LV;
                    end
                end
                MODE_LV: begin
                    if (hv_s) begin
                        mode <= MODE_HV;
                    end else if (!pgm_s) begin
                        mode <= MODE_USER;
                    end
                end
                MODE_HV: begin
                    if (!hv_s) begin
                        mode <= MODE_USER;
                    end
                end
                default: mode <= MODE_USER;
            endcase
        end
    end

    // =====================================================
    // Configuration bytes; reset stands in for the erased array
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_bor  <= CFG_ERASED;
            cfg_wdt  <= CFG_ERASED;
            cfg_dbg  <= DBG_ERASED;
            cfg_prot <= PROT_ERASED;
        end else if (pw) begin
            if (!cfg_locked) begin
                if (frame.addr == ADDR_BOR) begin
                    cfg_bor <= frame.data & CFG_MASK;
                end
                if (frame.addr == ADDR_WDT) begin
                    cfg_wdt <= frame.data & CFG_MASK;
                end
                if (frame.addr == ADDR_DBG) begin
                    cfg_dbg <= merge_dbg(cfg_dbg, frame.data, mode == MODE_HV);
                end
            end
            if (frame.addr == ADDR_PROT) begin
                cfg_prot <= frame.data & PROT_MASK;
            end
        end else if (cw && !cfg_locked) begin
            if (tbl_addr == ADDR_BOR) begin
                cfg_bor <= tbl_wdata & CFG_MASK;
            end
            if (tbl_addr == ADDR_WDT) begin
                cfg_wdt <= tbl_wdata & CFG_MASK;
            end
            if (tbl_addr == ADDR_DBG) begin
                cfg_dbg <= merge_dbg(cfg_dbg, tbl_wdata, 1'b0);
            end
        end
    end

    // =====================================================
    // ID locations
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < ID_COUNT; i++) begin
                id_mem[i] <= ID_ERASED;
            end
        end else if (pw && is_id(frame.addr)) begin
            id_mem[frame.addr[2:0]] <= frame.data;
        end else if (cw && is_id(tbl_addr)) begin
            id_mem[tbl_addr[2:0]] <= tbl_wdata;
        end
    end

    // =====================================================
    // CPU table reads, one-cycle answer
    always_ff @(posedge clk) begin
        if (rst) begin
            tbl_ack   <= 1'b0;
            tbl_rdata <= 8'h00;
        end else begin
            tbl_ack <= (tbl_rd || tbl_wr) && (mode == MODE_USER);
            if (tbl_rd && (mode == MODE_USER)) begin
                tbl_rdata <= read_byte(tbl_addr);
            end
        end
    end

    // =====================================================
    // External eeprom path
    always_ff @(posedge clk) begin
        if (rst) begin
            ee_ext_rd    <= 1'b0;
            ee_ext_wr    <= 1'b0;
            ee_ext_addr  <= 10'h000;
            ee_ext_wdata <= 8'h00;
            rd_pend      <= 1'b0;
        end else begin
            rd_pend   <= hdr_done && !frame.is_write && prog_act;
            ee_ext_rd <= hdr_done && !frame.is_write && prog_act
                         && is_ee(frame.addr) && ee_rd_ok;
            ee_ext_wr <= pw && is_ee(frame.addr) && ee_wr_ok;
            if (hdr_done) begin
                ee_ext_addr <= frame.addr[9:0];
            end
            if (pw) begin
                ee_ext_wdata <= frame.data;
            end
        end
    end

    // =====================================================
    // Decoded outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_out      <= cfp_decode(CFG_ERASED, CFG_ERASED, DBG_ERASED);
            watchdog_run <= 1'b1;
            pin5_gpio    <= 1'b0;
            prog_mode    <= 1'b0;
            prog_hv_mode <= 1'b0;
            cpu_ee_allow <= 1'b1;
        end else begin
            cfg_out      <= cfp_decode(cfg_bor, cfg_wdt, cfg_dbg);
            watchdog_run <= cfg_wdt[WDT_ON_BIT] | watchdog_soft_on;
            pin5_gpio    <= ~cfg_dbg[LVP_BIT];
            prog_mode    <= prog_act;
            prog_hv_mode <= (mode == MODE_HV);
            cpu_ee_allow <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            dbg_pins_reserved <= 1'b0;
            dbg_stack_levels  <= 2'h0;
            dbg_prog_bytes    <= 10'h000;
            dbg_data_bytes    <= 4'h0;
        end else begin
            dbg_pins_reserved <= ~cfg_dbg[DBG_OFF_BIT];
            dbg_stack_levels  <= cfg_dbg[DBG_OFF_BIT] ? 2'h0 : DBG_STACK_LEVELS;
            dbg_prog_bytes    <= cfg_dbg[DBG_OFF_BIT] ? 10'h000 : DBG_PROG_BYTES;
            dbg_data_bytes    <= cfg_dbg[DBG_OFF_BIT] ? 4'h0 : DBG_DATA_BYTES;
        end
    end

    // =====================================================
    // Checks
    a_hv_entry: assert property (@(posedge clk) disable iff (rst)
        hv_s |=> mode == MODE_HV) else $error("HV entry refused");
    a_lv_gated: assert property (@(posedge clk) disable iff (rst)
        (mode == MODE_USER && !hv_s && pgm_s && !cfg_dbg[LVP_BIT]) |=> mode == MODE_USER)
        else $error("LV entry while not allowed");
    a_unimpl_zero: assert property (@(posedge clk) disable iff (rst)
        (tbl_rd && mode == MODE_USER && (tbl_addr == ADDR_BOR || tbl_addr == ADDR_WDT))
        |=> tbl_ack && tbl_rdata[7:4] == 4'h0) else $error("Upper nibble not zero");
    a_wdt_ratio: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> cfg_out.wdt_ratio == (8'h01 << $past(cfg_wdt[3:1])))
        else $error("Postscale ratio wrong");
    a_wdt_force: assert property (@(posedge clk) disable iff (rst)
        cfg_wdt[WDT_ON_BIT] |=> watchdog_run) else $error("Watchdog not forced");
    a_cfg_lock: assert property (@(posedge clk) disable iff (rst)
        (cw && cfg_locked && tbl_addr == ADDR_BOR) |=> $stable(cfg_bor))
        else $error("Locked config written");
    a_prot_ro: assert property (@(posedge clk) disable iff (rst)
        (mode == MODE_USER) |=> $stable(cfg_prot)) else $error("Protect byte changed");
    a_ee_rd_lock: assert property (@(posedge clk) disable iff (rst)
        ee_ext_rd |-> $past(cfg_prot[PROT_EEA_BIT])) else $error("Locked eeprom read");
    a_ee_wr_lock: assert property (@(posedge clk) disable iff (rst)
        ee_ext_wr |-> $past(ee_wr_ok)) else $error("Locked eeprom write");
    a_lvp_hv_only: assert property (@(posedge clk) disable iff (rst)
        $changed(cfg_dbg[LVP_BIT]) |-> $past(mode) == MODE_HV)
        else $error("Allow bit changed outside HV");
    a_pin5_gpio: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> pin5_gpio == !$past(cfg_dbg[LVP_BIT])) else $error("Pin 5 role wrong");
endmodule : cfp_top

// ==== dv/cfp_pgm.sv ====
// Programmer model: link clock, link data, entry pin and high voltage.
// Assumes the bench resolves the shared data wire from the device enable.
module cfp_pgm (
    // Link pins driven
    output logic      sclk,
    output logic      sdat,
    output logic      entry,
    output logic      hv,
    // Resolved data wire
    input  wire logic dwire
);
    timeunit 1ns;
    timeprecision 100ps;

    // ====================
    // Idle: clock stands low between frames
    initial begin
        sclk = 1'b0;
        sdat = 1'b0;
        entry = 1'b0;
        hv = 1'b0;
    end

    task automatic mode(input logic e, input logic h);
        entry <= e;
        hv <= h;
        #200;
    endtask : mode

    // One frame, LSB first; data phase of a read is left to the device
    task automatic xfer(input logic w, input logic [21:0] a, input logic [7:0] d,
                        output logic [7:0] r);
        logic [30:0] f;
        f = {d, a, w};
        for (int i = 0; i < 31; i++) begin
            sdat <= (i > 22 && !w) ? ~sdat : f[i];
            #62.5 sclk <= 1'b1;
            if (i > 22) r[i-23] = dwire;
            #62.5 sclk <= 1'b0;
        end
        // Released line must not keep a stale value
        sdat <= ~sdat;
        #500;
    endtask : xfer
endmodule : cfp_pgm

// ==== dv/cfp_top_bench.sv ====
// Bench for the configuration fuse block: CPU table port and serial link.
// Assumes cfp_pkg and cfp_pgm are compiled first.
`define CHK(g, e) chk_val(32'(g), 32'(e))
module cfp_top_bench import cfp_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk, rst, tbl_rd, tbl_wr, tbl_ack, watchdog_soft_on, watchdog_run;
    logic [21:0] tbl_addr;
    logic [7:0]  tbl_wdata, tbl_rdata, rd, ee_ext_wdata, ee_rdata;
    logic [9:0]  ee_ext_addr, dbg_prog_bytes;
    logic [3:0]  dbg_data_bytes;
    logic [1:0]  dbg_stack_levels;
    logic        prog_clk_pin, sdat, prog_entry_pin, high_prog_voltage, prog_data_out;
    logic        prog_data_oe, prog_mode, prog_hv_mode, pin5_gpio, ee_ext_rd, ee_ext_wr;
    logic        cpu_ee_allow, dbg_pins_reserved;
    cfp_cfg_t    cfg_out;
    int          n_mismatch, checks, n_rd, n_wr;
    wire logic   dwire = prog_data_oe ? prog_data_out : sdat;
    logic [12:0] mv [4] = '{13'h1194, 13'h1068, 13'h0A8C, 13'h09C4};

    assign ee_rdata = ee_ext_addr[7:0] ^ 8'hA5;

    cfp_top cfp_top_inst (.clk, .rst, .tbl_rd, .tbl_wr, .tbl_addr, .tbl_wdata, .tbl_rdata,
        .tbl_ack, .watchdog_soft_on, .watchdog_run, .prog_clk_pin, .prog_data_in(dwire),
        .prog_data_out, .prog_data_oe, .prog_entry_pin, .high_prog_voltage, .prog_mode,
        .prog_hv_mode, .pin5_gpio, .ee_ext_rd, .ee_ext_wr, .ee_ext_addr, .ee_ext_wdata,
        .ee_rdata, .cpu_ee_allow, .cfg_out, .dbg_pins_reserved, .dbg_stack_levels,
        .dbg_prog_bytes, .dbg_data_bytes);
    cfp_pgm cfp_pgm_inst (.sclk(prog_clk_pin), .sdat, .entry(prog_entry_pin),
        .hv(high_prog_voltage), .dwire);

    // ====================
    // Clock, strobe counters, common tasks
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        n_rd <= n_rd + int'(ee_ext_rd);
        n_wr <= n_wr + int'(ee_ext_wr);
    end

    task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk_val

    task automatic cpu(input logic w, input logic [21:0] a, input logic [7:0] d,
                       input logic ack);
        @(posedge clk);
        tbl_rd <= !w;
        tbl_wr <= w;
        tbl_addr <= a;
        tbl_wdata <= d;
        @(posedge clk);
        tbl_rd <= 1'b0;
        tbl_wr <= 1'b0;
        #1 `CHK(tbl_ack, ack);
        rd = tbl_rdata;
        repeat (4) @(posedge clk);
    endtask : cpu

    // Only read frames carry a reply byte
    task automatic lnk(input logic w, input logic [21:0] a, input logic [7:0] d);
        logic [7:0] r;
        cfp_pgm_inst.xfer(w, a, d, r);
        if (!w) rd = r;
    endtask : lnk

    // ====================
    // Scenarios
    task automatic t_user;
        cpu(1'b0, 22'h30_0002, 8'h00, 1'b1);
        `CHK(rd, 8'h0F);
        `CHK(cfg_out, {13'h09C4, 1'b1, 1'b0, 8'h80, 1'b1, 1'b0, 1'b1});
        `CHK({watchdog_run, cpu_ee_allow, pin5_gpio, dbg_pins_reserved}, 4'hC);
        cpu(1'b0, 22'h20_0007, 8'h00, 1'b1);
        `CHK(rd, 8'hFF);
        cpu(1'b1, 22'h20_0001, 8'h3C, 1'b1);
        cpu(1'b0, 22'h20_0001, 8'h00, 1'b1);
        `CHK(rd, 8'h3C);
        cpu(1'b1, 22'h30_0009, 8'h00, 1'b1);
        cpu(1'b0, 22'h30_0009, 8'h00, 1'b1);
        `CHK(rd, 8'h07);
        for (int c = 0; c < 4; c++) begin
            cpu(1'b1, 22'h30_0002, 8'hF0 | 8'(c * 5), 1'b1);
            `CHK({cfg_out.bor_mv, cfg_out.bor_on, cfg_out.powerup_timer_on}, {mv[c], c[1], !c[0]});
            cpu(1'b0, 22'h30_0002, 8'h00, 1'b1);
            `CHK(rd, 8'(c * 5));
        end
        for (int c = 0; c < 16; c++) begin
            watchdog_soft_on <= c[2];
            cpu(1'b1, 22'h30_0003, 8'hF0 | 8'(c), 1'b1);
            `CHK({cfg_out.wdt_ratio, watchdog_run}, {8'h01 << c[3:1], c[0] | c[2]});
        end
        cpu(1'b1, 22'h30_0006, 8'h00, 1'b1);
        `CHK({dbg_pins_reserved, dbg_stack_levels, dbg_prog_bytes, dbg_data_bytes,
              cfg_out.lvp_on}, {1'b1, 2'h2, 10'h240, 4'hA, 1'b1});
    endtask : t_user

    task automatic t_low;
        cfp_pgm_inst.mode(1'b1, 1'b0);
        `CHK({prog_mode, prog_hv_mode}, 2'b10);
        cpu(1'b0, 22'h30_0002, 8'h00, 1'b0);
        lnk(1'b0, 22'h20_0003, 8'h00);
        `CHK(rd, 8'hFF);
        lnk(1'b1, 22'h20_0005, 8'hC3);
        lnk(1'b0, 22'h20_0005, 8'h00);
        `CHK(rd, 8'hC3);
        lnk(1'b1, 22'h30_0006, 8'h00);
        lnk(1'b0, 22'h30_0006, 8'h00);
        `CHK(rd, 8'h04);
        lnk(1'b0, 22'h3F_0012, 8'h00);
        `CHK({rd, 8'(n_rd)}, {8'hB7, 8'h01});
        cfp_pgm_inst.mode(1'b0, 1'b0);
    endtask : t_low

    task automatic t_high;
        cfp_pgm_inst.mode(1'b0, 1'b1);
        `CHK({prog_mode, prog_hv_mode}, 2'b11);
        lnk(1'b1, 22'h30_0006, 8'h80);
        `CHK({cfg_out.lvp_on, cfg_out.debug_on, pin5_gpio}, 3'b001);
        lnk(1'b1, 22'h30_0009, 8'h06);
        lnk(1'b0, 22'h3F_0001, 8'h00);
        lnk(1'b1, 22'h3F_0001, 8'h55);
        `CHK({rd, 8'(n_rd), 8'(n_wr)}, 24'h000100);
        lnk(1'b1, 22'h30_0009, 8'h05);
        lnk(1'b0, 22'h3F_0002, 8'h00);
        lnk(1'b1, 22'h3F_0002, 8'h55);
        `CHK({rd, 8'(n_rd), 8'(n_wr)}, 24'hA70200);
        lnk(1'b1, 22'h30_0009, 8'h03);
        lnk(1'b1, 22'h3F_0003, 8'h3C);
        `CHK({8'(n_wr), ee_ext_wdata, ee_ext_addr}, {8'h01, 8'h3C, 10'h003});
        cfp_pgm_inst.mode(1'b0, 1'b0);
        cpu(1'b1, 22'h30_0002, 8'h00, 1'b1);
        cpu(1'b0, 22'h30_0002, 8'h00, 1'b1);
        `CHK(rd, 8'h0F);
        cfp_pgm_inst.mode(1'b1, 1'b0);
        `CHK({prog_mode, pin5_gpio, cpu_ee_allow}, 3'b011);
        cfp_pgm_inst.mode(1'b1, 1'b1);
        `CHK({prog_mode, prog_hv_mode}, 2'b11);
    endtask : t_high

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_of_test

    initial begin
        rst = 1'b1;
        {tbl_rd, tbl_wr, tbl_addr, tbl_wdata, watchdog_soft_on} = '0;
        {n_mismatch, checks, n_rd, n_wr} = '0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_user();
        t_low();
        t_high();
        end_of_test();
    end
    // Whole run is near 66 us of link traffic
    initial begin
        #300000;
        n_mismatch++;
        end_of_test();
    end
endmodule : cfp_top_bench
